// ==== testbench/otsh_link_props.sv ====
// Concurrent checks on the register link of one device end
`timescale 1ns/100ps
module otsh_link_props (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Serial port
   input wire logic ser_wr,
   input wire logic ser_rd,
   input wire logic [otsh_pkg::ADDR_W-1:0] ser_addr,
   input wire logic [otsh_pkg::DATA_W-1:0] ser_wdata,
   input wire logic [otsh_pkg::DATA_W-1:0] ser_rdata,
   // Trim port and status
   input wire logic trim_wr,
   input wire logic [otsh_pkg::ADDR_W-1:0] trim_addr,
   input wire logic [otsh_pkg::DATA_W-1:0] trim_wdata,
   input wire logic busy
);
   import otsh_pkg::*;
   logic wr;
   logic shd;
   logic [7:0] wa;
   logic [7:0] wd;
   logic unl_q;
   logic unl_d;
   logic [1:0] mode_q;
   logic [1:0] mode_d;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   // Reference copy of unlock and select; serial wins a clash
   always_comb begin
      wr = ser_wr | trim_wr;
      wa = ser_wr ? ser_addr : trim_addr;
      wd = ser_wr ? ser_wdata : trim_wdata;
      shd = (ser_addr >= SHD_LO_BASE && ser_addr <= 8'h17)
         || (ser_addr >= SHD_HI_BASE && ser_addr <= SHD_HI_END);
      unl_d = unl_q;
      mode_d = mode_q;
      if (wr && !busy && wa == ADR_SYS) unl_d = wd[UNLOCK_BIT];
      if (wr && !busy && wa == ADR_MODE && unl_q) mode_d = wd[1:0];
   end

   // Registered copy, cleared like the device
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         unl_q <= 1'b0;
         mode_q <= 2'h0;
      end else begin
         unl_q <= unl_d;
         mode_q <= mode_d;
      end
   end

   reset_load_len_a: assert property ($fell(i_reset) |-> ##[0:1] busy[*8] ##1 busy[*5]
      ##[1:2] !busy) else $error("load after reset has wrong length");
   op_busy_len_a: assert property (wr && !busy && unl_q && wa == ADR_MODE && wd[0]
      |=> busy[*8] ##1 busy[*5] ##[1:2] !busy) else $error("load or burn has wrong length");
   busy_cause_a: assert property ($rose(busy) && !$past(i_reset) && !$past(i_reset, 2)
      |-> $past(wr && unl_q && wa == ADR_MODE && wd[0])) else $error("busy without a start");
   rdata_idle_a: assert property (!$past(ser_rd) |-> ser_rdata == 8'h00)
      else $error("read data outside the answer cycle");
   mode_read_a: assert property (ser_rd && ser_addr == ADR_MODE |=>
      ser_rdata[1:0] == mode_q && ser_rdata[BUSY_BIT] == $past(busy))
      else $error("select field read back wrong");
   unlock_read_a: assert property (ser_rd && ser_addr == ADR_SYS
      |=> ser_rdata[UNLOCK_BIT] == unl_q) else $error("unlock bit read back wrong");
   shadow_gate_a: assert property (ser_rd && shd && (mode_q != MODE_READ || busy)
      |=> ser_rdata == 8'h00) else $error("shadow read without read access");
   unmapped_zero_a: assert property (ser_rd && ser_addr == 8'h00 |=> ser_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule : otsh_link_props

// ==== testbench/otsh_tb_top.sv ====
// Bench: host and device joined, plus a second device driven directly
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module otsh_tb_top;
   import otsh_pkg::*;
   typedef struct packed {
      logic [1:0] cmd;
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] rd;
      logic err;
   } otsh_row_type;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic start = 1'b0;
   logic [1:0] cmd = 2'h0;
   logic [7:0] adr = 8'h00;
   logic [7:0] wdat = 8'h00;
   logic ready;
   logic done;
   logic err;
   logic unl_b;
   logic busy_b;
   logic [1:0] mode_b;
   logic [5:0] gr_b;
   logic [5:0] gl_b;
   logic [7:0] rdat;
   logic [7:0] d;
   logic [111:0] shd_b;
   int fails = 0;
   int n_compared = 0;
   int cyc = 0;
   // Host flow: reads, writes, loads and trims in order
   otsh_row_type rows [21] = '{
      '{HC_READ, 8'h10, 8'h00, 8'h80, 1'b0}, '{HC_WRITE, 8'h11, 8'h15, 8'h00, 1'b0},
      '{HC_READ, 8'h11, 8'h00, 8'h15, 1'b0}, '{HC_WRITE, 8'h11, 8'h2A, 8'h00, 1'b0},
      '{HC_READ, 8'h11, 8'h00, 8'h2A, 1'b0}, '{HC_LOAD, 8'h00, 8'h00, 8'h00, 1'b0},
      '{HC_READ, 8'h11, 8'h00, 8'h00, 1'b0}, '{HC_WRITE, 8'h32, 8'h11, 8'h00, 1'b0},
      '{HC_TRIM, 8'h00, 8'h00, 8'h00, 1'b0}, '{HC_WRITE, 8'h32, 8'h00, 8'h00, 1'b0},
      '{HC_LOAD, 8'h00, 8'h00, 8'h00, 1'b0}, '{HC_READ, 8'h32, 8'h00, 8'h11, 1'b0},
      '{HC_WRITE, 8'h32, 8'h22, 8'h00, 1'b0}, '{HC_TRIM, 8'h00, 8'h00, 8'h00, 1'b1},
      '{HC_LOAD, 8'h00, 8'h00, 8'h00, 1'b0}, '{HC_READ, 8'h32, 8'h00, 8'h33, 1'b0},
      '{HC_WRITE, 8'h30, 8'h01, 8'h00, 1'b0}, '{HC_READ, 8'h30, 8'h00, 8'h81, 1'b0},
      '{HC_TRIM, 8'h00, 8'h00, 8'h00, 1'b1}, '{HC_LOAD, 8'h00, 8'h00, 8'h00, 1'b0},
      '{HC_READ, 8'h30, 8'h00, 8'h80, 1'b0}};
   otsh_link_if link_a ();
   otsh_link_if link_b ();

   otsh_dev u_otsh_dev (.i_clk(i_clk), .i_reset(i_reset), .link(link_a), .o_shadow(),
      .o_gain_r(), .o_gain_l(), .o_unlock(), .o_mode(), .o_busy());
   otsh_host #(.SETTLE_CYC(4)) u_otsh_host (.i_clk(i_clk), .i_reset(i_reset), .link(link_a),
      .i_start(start), .i_cmd(cmd), .i_addr(adr), .i_wdata(wdat), .o_ready(ready),
      .o_done(done), .o_error(err), .o_rdata(rdat), .o_power_ctrl_serial_clock_pin());
   otsh_dev u_otsh_dev_b (.i_clk(i_clk), .i_reset(i_reset), .link(link_b), .o_shadow(shd_b),
      .o_gain_r(gr_b), .o_gain_l(gl_b), .o_unlock(unl_b), .o_mode(mode_b), .o_busy(busy_b));
   // Checks watch the hand-driven link: the host never reads 20h, 3Fh or gated shadows
   otsh_link_props u_otsh_link_props (.i_clk(i_clk), .i_reset(i_reset),
      .ser_wr(link_b.ser_wr), .ser_rd(link_b.ser_rd), .ser_addr(link_b.ser_addr),
      .ser_wdata(link_b.ser_wdata), .ser_rdata(link_b.ser_rdata), .trim_wr(link_b.trim_wr),
      .trim_addr(link_b.trim_addr), .trim_wdata(link_b.trim_wdata), .busy(link_b.busy));

   // Free-running clock
   always #5 i_clk = ~i_clk;

   // Hang guard, well above the few hundred cycles needed
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end

   // One write cycle on the second device; p picks trim port
   task automatic bw(input logic p, input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clk);
      if (p) begin
         link_b.trim_wr <= 1'b1;
         link_b.trim_addr <= a;
         link_b.trim_wdata <= v;
      end else begin
         link_b.ser_wr <= 1'b1;
         link_b.ser_addr <= a;
         link_b.ser_wdata <= v;
      end
      @(posedge i_clk);
      link_b.ser_wr <= 1'b0;
      link_b.trim_wr <= 1'b0;
      link_b.ser_wdata <= ~v;
      link_b.trim_wdata <= ~v;
      #1;
   endtask : bw

   // One read cycle; data taken in the answer cycle only
   task automatic br(input logic p, input logic [7:0] a, output logic [7:0] v);
      @(posedge i_clk);
      if (p) link_b.trim_rd <= 1'b1;
      else link_b.ser_rd <= 1'b1;
      link_b.ser_addr <= a;
      link_b.trim_addr <= a;
      @(posedge i_clk);
      link_b.ser_rd <= 1'b0;
      link_b.trim_rd <= 1'b0;
      #1;
      v = p ? link_b.trim_rdata : link_b.ser_rdata;
   endtask : br

   // Bounded wait for the second device to go idle
   task automatic idle_b();
      for (int k = 0; k < 40 && busy_b !== 1'b0; k++) begin
         @(posedge i_clk);
         #1;
      end
      #1;
   endtask : idle_b

   // One host command, waited on through its done pulse
   task automatic run(input otsh_row_type r);
      for (int k = 0; k < 50 && ready !== 1'b1; k++) #10;
      @(posedge i_clk);
      start <= 1'b1;
      cmd <= r.cmd;
      adr <= r.adr;
      wdat <= r.wd;
      @(posedge i_clk);
      start <= 1'b0;
      // Look just after each edge so the one-cycle done pulse is not raced
      for (int k = 0; k < 600 && done !== 1'b1; k++) begin
         @(posedge i_clk);
         #1;
      end
      `CHK("done", 1'b1, done)
      if (r.cmd == HC_READ) `CHK("rdata", r.rd, rdat)
      `CHK("error", r.err, err)
   endtask : run

   task automatic wrap_up();
      if (fails == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up

   // Main sequence
   initial begin
      link_b.ser_wr = 1'b0;
      link_b.ser_rd = 1'b0;
      link_b.trim_wr = 1'b0;
      link_b.trim_rd = 1'b0;
      link_b.ser_addr = 8'h00;
      link_b.trim_addr = 8'h00;
      link_b.ser_wdata = 8'h00;
      link_b.trim_wdata = 8'h00;
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      #1;
      foreach (rows[i]) run(rows[i]);
      idle_b();
      br(0, ADR_MODE, d);
      `CHK("select idle", 8'h00, d)
      bw(0, ADR_MODE, 8'h02);
      `CHK("locked select", 2'h0, mode_b)
      bw(0, ADR_SYS, 8'h08);
      `CHK("unlock", 1'b1, unl_b)
      br(0, ADR_SYS, d);
      `CHK("unlock read", 8'h08, d)
      bw(0, ADR_MODE, 8'h02);
      `CHK("select", MODE_WRITE, mode_b)
      bw(1, 8'h14, 8'h5A);
      bw(0, 8'h30, 8'h07);
      bw(0, 8'h31, 8'h09);
      br(0, 8'h14, d);
      `CHK("gated read", 8'h00, d)
      `CHK("gain", 6'h07, gr_b)
      `CHK("gain left", 6'h09, gl_b)
      // Second gain set enabled takes over the left gain
      bw(0, 8'h11, 8'h85);
      bw(0, ADR_MODE, 8'h00);
      `CHK("alt gain", 6'h05, gl_b)
      br(1, 8'h14, d);
      `CHK("trim read", 8'h5A, d)
      br(0, 8'h00, d);
      `CHK("unmapped", 8'h00, d)
      bw(0, ADR_MODE, 8'h01);
      `CHK("busy", 1'b1, busy_b)
      bw(0, ADR_MODE, 8'h02);
      `CHK("select kept", MODE_LOAD, mode_b)
      idle_b();
      bw(0, ADR_MODE, 8'h00);
      br(1, 8'h14, d);
      `CHK("loaded", 8'h00, d)
      `CHK("test bit", 8'h80, shd_b[7:0])
      bw(0, ADR_MODE, 8'h02);
      bw(0, 8'h14, 8'h33);
      // Mid-run reset loses written shadows
      @(posedge i_clk);
      i_reset <= 1'b1;
      repeat (10) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (2) @(posedge i_clk);
      idle_b();
      `CHK("shadow after reset", 8'h00, shd_b[39:32])
      `CHK("unlock after reset", 1'b0, unl_b)
      wrap_up();
   end
endmodule : otsh_tb_top

// ==== verilog/otsh_dev.sv ====
// Device end: fuse array, shadow registers and their access control
`timescale 1ns/100ps

// What this block does
// [R1] Load copies fuses into shadow registers
// [R2] Automatic load after every power-on reset
// [R3] Shadow write never programs a fuse
// [R4] Written value holds until write or load
// [R5] Host writes override loaded values, unlimited
// [R6] Read returns current shadow contents
// [R7] Store programs shadow contents into fuses
// [R8] Access select reachable only when unlocked
// [R9] Select code 00 grants shadow reads
// [R10] Select code 10 grants shadow writes
// [R11] Host unlocks, selects, then accesses
// [R12] Host loads before reading fuse contents
// [R13] Fuse bits only go from zero to one
// [R14] Host trims only if both gains untrimmed
// [R15] Host saves shadows, verifies after programming
// [R16] Test bits reset to one, left alone
// [R17] Host waits 1 ms supply settle
// [R18] Serial and trim ports both reach shadows
// [R19] Select codes: 0 read, 1 load, 3 burn
// [R20] Shadows at 10h-17h and 30h-35h
// [R21] Three gain fuse sets, later ones override
// [R22] Locked select writes are ignored
module otsh_dev #(
   parameter logic [otsh_pkg::SHD_N*otsh_pkg::DATA_W-1:0] FUSE_PRESET = '0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Register link
   otsh_link_if.dev link,
   // Configuration for the analog core
   output logic [otsh_pkg::SHD_N*otsh_pkg::DATA_W-1:0] o_shadow,
   output logic [otsh_pkg::GAIN_W-1:0] o_gain_r,
   output logic [otsh_pkg::GAIN_W-1:0] o_gain_l,
   // Status
   output logic o_unlock,
   output logic [otsh_pkg::MODE_W-1:0] o_mode,
   output logic o_busy
);
   import otsh_pkg::*;

   typedef enum logic [1:0] {DS_LOAD, DS_IDLE, DS_BURN} otsh_dstate_type;

   otsh_dstate_type state_q;
   otsh_dstate_type state_d;
   logic [IDX_W-1:0] idx_q;
   logic [IDX_W-1:0] idx_d;
   logic [DATA_W-1:0] shd_q [SHD_N];
   logic [DATA_W-1:0] shd_d [SHD_N];
   logic [DATA_W-1:0] fuse_q [SHD_N];
   logic [DATA_W-1:0] fuse_d [SHD_N];
   logic unlock_q;
   logic unlock_d;
   logic [MODE_W-1:0] mode_q;
   logic [MODE_W-1:0] mode_d;
   logic [DATA_W-1:0] ser_rd_q;
   logic [DATA_W-1:0] ser_rd_d;
   logic [DATA_W-1:0] trim_rd_q;
   logic [DATA_W-1:0] trim_rd_d;
   logic [GAIN_W-1:0] gain_r_q;
   logic [GAIN_W-1:0] gain_r_d;
   logic [GAIN_W-1:0] gain_l_q;
   logic [GAIN_W-1:0] gain_l_d;
   logic req_wr;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata;

   // Read view of one register address
   function automatic logic [DATA_W-1:0] rd_byte(input logic [ADDR_W-1:0] a);
      logic [DATA_W-1:0] v;
      v = '0;
      if (a == ADR_SYS) begin
         v[UNLOCK_BIT] = unlock_q;
      end else if (a == ADR_MODE) begin
         v[MODE_W-1:0] = mode_q;
         v[BUSY_BIT] = (state_q != DS_IDLE);
      // [R9] Read grant on code 00
      // [R20] Two shadow address ranges
      end else if (shd_hit(a) && mode_q == MODE_READ && state_q == DS_IDLE) begin
         // [R6] Current shadow contents
         v = shd_q[shd_idx(a)];
      end
      return v;
   endfunction : rd_byte

   // [R18] Either port may write; serial wins a same-cycle clash
   always_comb begin
      req_wr = link.ser_wr | link.trim_wr;
      req_addr = link.ser_wr ? link.ser_addr : link.trim_addr;
      req_wdata = link.ser_wr ? link.ser_wdata : link.trim_wdata;
   end

   // [R18] Reads are side-effect free, so both ports read at once
   always_comb begin
      ser_rd_d = link.ser_rd ? rd_byte(link.ser_addr) : '0;
      trim_rd_d = link.trim_rd ? rd_byte(link.trim_addr) : '0;
   end

   // Sequencer for load and burn, and register writes
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      shd_d = shd_q;
      fuse_d = fuse_q;
      unlock_d = unlock_q;
      mode_d = mode_q;
      unique case (state_q)
         DS_LOAD: begin
            // [R1] Fuse byte replaces shadow byte
            shd_d[idx_q] = fuse_q[idx_q];
            idx_d = (idx_q == IDX_LAST) ? '0 : idx_q + 1'b1;
            state_d = (idx_q == IDX_LAST) ? DS_IDLE : DS_LOAD;
         end
         DS_BURN: begin
            // [R7] Shadow byte burnt into fuses
            // [R13] OR keeps programmed bits set
            fuse_d[idx_q] = fuse_q[idx_q] | shd_q[idx_q];
            idx_d = (idx_q == IDX_LAST) ? '0 : idx_q + 1'b1;
            state_d = (idx_q == IDX_LAST) ? DS_IDLE : DS_BURN;
         end
         DS_IDLE: begin
            // Writes are dropped while a load or burn runs
            if (req_wr) begin
               if (req_addr == ADR_SYS) begin
                  unlock_d = req_wdata[UNLOCK_BIT];
               // [R8] Select field needs the unlock bit
               // [R22] Locked writes leave the field alone
               end else if (req_addr == ADR_MODE && unlock_q) begin
                  mode_d = req_wdata[MODE_W-1:0];
                  // [R19] Codes 1 and 3 start an operation
                  if (req_wdata[MODE_W-1:0] == MODE_LOAD) begin
                     state_d = DS_LOAD;
                  end else if (req_wdata[MODE_W-1:0] == MODE_BURN) begin
                     state_d = DS_BURN;
                  end
               // [R10] Write grant on code 10
               end else if (shd_hit(req_addr) && mode_q == MODE_WRITE) begin
                  // [R3] Only the volatile copy changes
                  // [R5] Unlimited overrides of loaded values
                  shd_d[shd_idx(req_addr)] = req_wdata;
               end
            end
         end
      endcase
   end

   // [R21] Latest enabled gain set wins
   always_comb begin
      if (shd_q[IDX_L3][ALT_POS]) begin
         gain_r_d = shd_q[IDX_R3][GAIN_W-1:0];
         gain_l_d = shd_q[IDX_L3][GAIN_W-1:0];
      end else if (shd_q[IDX_L2][ALT_POS]) begin
         gain_r_d = shd_q[IDX_R2][GAIN_W-1:0];
         gain_l_d = shd_q[IDX_L2][GAIN_W-1:0];
      end else begin
         gain_r_d = shd_q[IDX_GR][GAIN_W-1:0];
         gain_l_d = shd_q[IDX_GL][GAIN_W-1:0];
      end
   end

   // State registers; fuses are flops, so a reset models a fresh part
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         // [R2] Reset starts with a full load
         state_q <= DS_LOAD;
         idx_q <= '0;
         unlock_q <= 1'b0;
         mode_q <= MODE_READ;
         ser_rd_q <= '0;
         trim_rd_q <= '0;
         gain_r_q <= '0;
         gain_l_q <= '0;
         for (int i = 0; i < SHD_N; i++) begin
            // [R16] Test bits come up at one
            shd_q[i] <= test_mask(IDX_W'(i));
            fuse_q[i] <= test_mask(IDX_W'(i)) | FUSE_PRESET[i*DATA_W +: DATA_W];
         end
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         // [R4] Shadows hold until write or load
         shd_q <= shd_d;
         fuse_q <= fuse_d;
         unlock_q <= unlock_d;
         mode_q <= mode_d;
         ser_rd_q <= ser_rd_d;
         trim_rd_q <= trim_rd_d;
         gain_r_q <= gain_r_d;
         gain_l_q <= gain_l_d;
      end
   end

   // Flatten shadows for the analog core
   always_comb begin
      for (int i = 0; i < SHD_N; i++) begin
         o_shadow[i*DATA_W +: DATA_W] = shd_q[i];
      end
   end

   // Outputs
   assign link.ser_rdata = ser_rd_q;
   assign link.trim_rdata = trim_rd_q;
   assign link.busy = (state_q != DS_IDLE);
   assign o_busy = (state_q != DS_IDLE);
   assign o_unlock = unlock_q;
   assign o_mode = mode_q;
   assign o_gain_r = gain_r_q;
   assign o_gain_l = gain_l_q;
endmodule : otsh_dev

// ==== verilog/otsh_host.sv ====
// Host end: command sequencer driving the register link
`timescale 1ns/100ps
module otsh_host #(
   parameter bit USE_TRIM = 1'b0,
   parameter int SETTLE_CYC = otsh_pkg::SETTLE_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Register link
   otsh_link_if.host link,
   // User command
   input wire logic i_start,
   input wire logic [1:0] i_cmd,
   input wire logic [otsh_pkg::ADDR_W-1:0] i_addr,
   input wire logic [otsh_pkg::DATA_W-1:0] i_wdata,
   // User result
   output logic o_ready,
   output logic o_done,
   output logic o_error,
   output logic [otsh_pkg::DATA_W-1:0] o_rdata,
   // Power control level to the device
   output logic o_power_ctrl_serial_clock_pin
);
   import otsh_pkg::*;

   localparam int CNT_W = $clog2(SETTLE_CYC + 1);

   typedef enum logic [3:0] {
      HS_SETTLE, HS_IDLE, HS_UNLOCK, HS_MODE, HS_ACC, HS_CAP, HS_DUMP, HS_DCAP, HS_WAIT, HS_DONE
   } otsh_hstate_type;
   typedef enum logic [1:0] {PH_SAVE, PH_BURN, PH_LOAD, PH_VERIFY} otsh_phase_type;

   otsh_hstate_type st_q;
   otsh_hstate_type st_d;
   otsh_phase_type ph_q;
   otsh_phase_type ph_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [1:0] cmd_q;
   logic [1:0] cmd_d;
   logic [MODE_W-1:0] mode_q;
   logic [MODE_W-1:0] mode_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] wdata_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [IDX_W-1:0] idx_q;
   logic [IDX_W-1:0] idx_d;
   logic [DATA_W-1:0] save_q [SHD_N];
   logic [DATA_W-1:0] save_d [SHD_N];
   logic err_q;
   logic err_d;
   logic done_q;
   logic done_d;
   logic b_wr;
   logic b_rd;
   logic [ADDR_W-1:0] b_addr;
   logic [DATA_W-1:0] b_wd;
   logic [DATA_W-1:0] rdat;

   // Link access for the current step
   always_comb begin
      b_wr = 1'b0;
      b_rd = 1'b0;
      b_addr = '0;
      b_wd = '0;
      unique case (st_q)
         // [R11] Unlock first, then select, then access
         HS_UNLOCK: begin
            b_wr = 1'b1;
            b_addr = ADR_SYS;
            b_wd[UNLOCK_BIT] = 1'b1;
         end
         HS_MODE: begin
            b_wr = 1'b1;
            b_addr = ADR_MODE;
            b_wd[MODE_W-1:0] = mode_q;
         end
         HS_ACC: begin
            b_wr = (cmd_q == HC_WRITE);
            b_rd = (cmd_q == HC_READ);
            b_addr = addr_q;
            // [R16] Test bits are kept at one
            b_wd = wdata_q | (shd_hit(addr_q) ? test_mask(shd_idx(addr_q)) : '0);
         end
         HS_DUMP: begin
            b_rd = 1'b1;
            b_addr = shd_addr(idx_q);
         end
         HS_SETTLE, HS_IDLE, HS_CAP, HS_DCAP, HS_WAIT, HS_DONE: begin
         end
      endcase
   end

   // Port choice is fixed per build
   assign link.ser_wr = b_wr & !USE_TRIM;
   assign link.ser_rd = b_rd & !USE_TRIM;
   assign link.ser_addr = b_addr;
   assign link.ser_wdata = b_wd;
   assign link.trim_wr = b_wr & USE_TRIM;
   assign link.trim_rd = b_rd & USE_TRIM;
   assign link.trim_addr = b_addr;
   assign link.trim_wdata = b_wd;
   assign rdat = USE_TRIM ? link.trim_rdata : link.ser_rdata;

   // Command sequencer
   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      cnt_d = cnt_q;
      cmd_d = cmd_q;
      mode_d = mode_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      idx_d = idx_q;
      save_d = save_q;
      err_d = err_q;
      done_d = 1'b0;
      unique case (st_q)
         // [R17] No access before the supply settles
         HS_SETTLE: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
               // Hold until the power-on load ends, else the unlock write is dropped
               cnt_d = cnt_q;
               if (!link.busy) begin
                  st_d = HS_IDLE;
               end
            end
         end
         HS_IDLE: begin
            if (i_start) begin
               cmd_d = i_cmd;
               addr_d = i_addr;
               wdata_d = i_wdata;
               err_d = 1'b0;
               idx_d = '0;
               ph_d = PH_SAVE;
               mode_d = (i_cmd == HC_WRITE) ? MODE_WRITE
                  : (i_cmd == HC_LOAD) ? MODE_LOAD : MODE_READ;
               st_d = HS_UNLOCK;
            end
         end
         HS_UNLOCK: st_d = HS_MODE;
         HS_MODE: begin
            if (mode_q == MODE_LOAD || mode_q == MODE_BURN) begin
               st_d = HS_WAIT;
            end else begin
               st_d = (cmd_q == HC_TRIM) ? HS_DUMP : HS_ACC;
            end
         end
         HS_ACC: st_d = (cmd_q == HC_READ) ? HS_CAP : HS_DONE;
         HS_CAP: begin
            rdata_d = rdat;
            st_d = HS_DONE;
         end
         HS_DUMP: st_d = HS_DCAP;
         HS_DCAP: begin
            // [R15] Save before, compare after
            if (ph_q == PH_SAVE) begin
               save_d[idx_q] = rdat;
            end else if (rdat != save_q[idx_q]) begin
               err_d = 1'b1;
            end
            if (idx_q != IDX_LAST) begin
               idx_d = idx_q + 1'b1;
               st_d = HS_DUMP;
            end else begin
               idx_d = '0;
               st_d = HS_DONE;
               // [R14] Burn only an untrimmed part
               if (ph_q == PH_SAVE) begin
                  if (save_q[IDX_GR] == GAIN_BLANK && save_q[IDX_GL] == GAIN_BLANK) begin
                     ph_d = PH_BURN;
                     mode_d = MODE_BURN;
                     st_d = HS_MODE;
                  end else begin
                     err_d = 1'b1;
                  end
               end
            end
         end
         HS_WAIT: begin
            if (!link.busy) begin
               if (cmd_q == HC_LOAD) begin
                  st_d = HS_DONE;
               // [R12] Fuses are seen only through a load
               end else if (ph_q == PH_BURN) begin
                  ph_d = PH_LOAD;
                  mode_d = MODE_LOAD;
                  st_d = HS_MODE;
               end else begin
                  ph_d = PH_VERIFY;
                  mode_d = MODE_READ;
                  st_d = HS_MODE;
               end
            end
         end
         HS_DONE: begin
            done_d = 1'b1;
            st_d = HS_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_q <= HS_SETTLE;
         ph_q <= PH_SAVE;
         cnt_q <= '0;
         cmd_q <= HC_READ;
         mode_q <= MODE_READ;
         addr_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         idx_q <= '0;
         err_q <= 1'b0;
         done_q <= 1'b0;
         for (int i = 0; i < SHD_N; i++) begin
            save_q[i] <= '0;
         end
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         mode_q <= mode_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         idx_q <= idx_d;
         save_q <= save_d;
         err_q <= err_d;
         done_q <= done_d;
      end
   end

   // Outputs
   assign o_ready = (st_q == HS_IDLE);
   assign o_done = done_q;
   assign o_error = err_q;
   assign o_rdata = rdata_q;
   assign o_power_ctrl_serial_clock_pin = 1'b1;
endmodule : otsh_host

// ==== verilog/otsh_link_if.sv ====
// Register link between host and device: serial port and trim port
`timescale 1ns/100ps
interface otsh_link_if;
   import otsh_pkg::*;
   logic ser_wr;
   logic ser_rd;
   logic [ADDR_W-1:0] ser_addr;
   logic [DATA_W-1:0] ser_wdata;
   logic [DATA_W-1:0] ser_rdata;
   logic trim_wr;
   logic trim_rd;
   logic [ADDR_W-1:0] trim_addr;
   logic [DATA_W-1:0] trim_wdata;
   logic [DATA_W-1:0] trim_rdata;
   logic busy;

   modport dev (
      input ser_wr, ser_rd, ser_addr, ser_wdata, trim_wr, trim_rd, trim_addr, trim_wdata,
      output ser_rdata, trim_rdata, busy
   );
   modport host (
      output ser_wr, ser_rd, ser_addr, ser_wdata, trim_wr, trim_rd, trim_addr, trim_wdata,
      input ser_rdata, trim_rdata, busy
   );
endinterface : otsh_link_if

// ==== verilog/otsh_pkg.sv ====
// Shared constants and helpers for the fuse and shadow register block
package otsh_pkg;
   // Widths and sizes
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int SHD_N = 14;
   localparam int IDX_W = 4;
   localparam int MODE_W = 2;
   localparam int GAIN_W = 6;
   localparam int SHD_LO_N = 8;
   // Register addresses
   localparam logic [7:0] ADR_SYS = 8'h20;
   localparam logic [7:0] ADR_MODE = 8'h3F;
   localparam logic [7:0] SHD_LO_BASE = 8'h10;
   localparam logic [7:0] SHD_HI_BASE = 8'h30;
   localparam logic [7:0] SHD_HI_END = 8'h35;
   // Field positions
   localparam int UNLOCK_BIT = 3;
   localparam int BUSY_BIT = 7;
   localparam int TEST_POS = 7;
   localparam int ALT_POS = 7;
   // Access select codes
   localparam logic [1:0] MODE_READ = 2'h0;
   localparam logic [1:0] MODE_LOAD = 2'h1;
   localparam logic [1:0] MODE_WRITE = 2'h2;
   localparam logic [1:0] MODE_BURN = 2'h3;
   // Host user commands
   localparam logic [1:0] HC_READ = 2'h0;
   localparam logic [1:0] HC_WRITE = 2'h1;
   localparam logic [1:0] HC_LOAD = 2'h2;
   localparam logic [1:0] HC_TRIM = 2'h3;
   // Shadow indices with a meaning of their own
   localparam logic [SHD_N-1:0] TEST_IDX = 14'h2345;
   localparam logic [IDX_W-1:0] IDX_R2 = 4'h0;
   localparam logic [IDX_W-1:0] IDX_L2 = 4'h1;
   localparam logic [IDX_W-1:0] IDX_R3 = 4'h2;
   localparam logic [IDX_W-1:0] IDX_L3 = 4'h3;
   localparam logic [IDX_W-1:0] IDX_GR = 4'h8;
   localparam logic [IDX_W-1:0] IDX_GL = 4'h9;
   localparam logic [IDX_W-1:0] IDX_LAST = 4'hD;
   localparam logic [7:0] GAIN_BLANK = 8'h80;
   // Supply settle time after power-up
   localparam int SETTLE_NS = 1000000;
   localparam int CLK_NS = 10;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   // Address falls in a shadow range
   function automatic logic shd_hit(input logic [7:0] a);
      return (a >= SHD_LO_BASE && a < SHD_LO_BASE + 8'(SHD_LO_N))
         || (a >= SHD_HI_BASE && a <= SHD_HI_END);
   endfunction : shd_hit

   // Address to shadow index
   function automatic logic [IDX_W-1:0] shd_idx(input logic [7:0] a);
      logic [7:0] r;
      r = (a >= SHD_HI_BASE) ? a - SHD_HI_BASE + 8'(SHD_LO_N) : a - SHD_LO_BASE;
      return r[IDX_W-1:0];
   endfunction : shd_idx

   // Shadow index to address
   function automatic logic [7:0] shd_addr(input logic [IDX_W-1:0] i);
      return (i < IDX_W'(SHD_LO_N)) ? SHD_LO_BASE + 8'(i)
         : SHD_HI_BASE + 8'(i) - 8'(SHD_LO_N);
   endfunction : shd_addr

   // Test bits that sit at one
   function automatic logic [7:0] test_mask(input logic [IDX_W-1:0] i);
      logic [7:0] m;
      m = 8'h00;
      m[TEST_POS] = TEST_IDX[i];
      return m;
   endfunction : test_mask
endpackage : otsh_pkg
